// ===== verif/core_xfer_model.sv
// Core model issuing coprocessor transfers to the register bank
module core_xfer_model (
    // Clock
    input  wire logic        clk_sys,
    // Coprocessor transfer port
    output logic             cpWrite,
    output logic             cpRead,
    output logic [3:0]       cpReg,
    output logic [2:0]       cpOp2,
    output logic [31:0]      cpWdata,
    input  wire logic [31:0] cpRdata
);
    timeunit 1ns;
    timeprecision 100ps;

    // Idle port, secondary opcode resting at zero
    initial begin
        cpWrite = 1'b0;
        cpRead = 1'b0;
        cpReg = 4'h0;
        cpOp2 = 3'h0;
        cpWdata = 32'h0000_0000;
    end

    // One-cycle write; reserved register and clock code are never sent
    task automatic wr(input logic [3:0] r, input logic [31:0] d, input logic [31:0] m);
        if (r == 4'h4 || (r == 4'h1 && d[31:30] == 2'b10))
            return;
        @(posedge clk_sys);
        #1;
        cpWrite = 1'b1;
        cpReg = r;
        cpWdata = d & m; // Undefined bits written as zero
        @(posedge clk_sys);
        #1;
        cpWrite = 1'b0;
        cpWdata = ~(d & m); // Released data must not keep the old value
    endtask

    // One-cycle read; registered answer is settled after the taking edge
    task automatic rd(input logic [3:0] r, input logic [2:0] op, output logic [31:0] q);
        @(posedge clk_sys);
        #1;
        cpRead = 1'b1;
        cpReg = r;
        cpOp2 = op;
        @(posedge clk_sys);
        #1;
        cpRead = 1'b0;
        cpOp2 = 3'h0;
        q = cpRdata;
    endtask
endmodule

// ===== verif/test_sysctrl_coproc_mmu_regs.sv
// Self-checking bench for the system control register bank
`include "sysctrl_defs.svh"
module test_sysctrl_coproc_mmu_regs;
    timeunit 1ns;
    timeprecision 100ps;
    import sysctrl_pkg::*;

    logic clk_sys = 1'b0;
    logic reset_n, cpWrite, cpRead, dataAbort, prefetchAbort;
    logic [3:0] cpReg, abortType, abortDomain, checkDomain;
    logic [2:0] cpOp2;
    logic [31:0] cpWdata, cpRdata, abortAddr, vectorBase, tableBase, domainWord;
    logic domainFault, checkPerms, mmuEnable, alignCheck, dcacheEnable, icacheEnable;
    logic bigEndian, sysProtect, romProtect, roundRobin;
    logic [15:0] managerMap;
    clock_mode_e clockMode;
    int err_count = 0;
    int n_checks = 0;
    int cycles = 0;
    int unsigned mReg [7];
    logic [15:0] seed = 16'h8CA4;
    logic [31:0] ident, cache, d;

    sysctrl_coproc_mmu_regs DUT (.clk_sys, .reset_n, .cpWrite, .cpRead, .cpReg, .cpOp2,
        .cpWdata, .cpRdata, .dataAbort, .prefetchAbort, .abortType, .abortDomain,
        .abortAddr, .checkDomain, .domainFault, .checkPerms, .managerMap, .mmuEnable,
        .alignCheck, .dcacheEnable, .icacheEnable, .bigEndian, .sysProtect, .romProtect,
        .vectorBase, .roundRobin, .clockMode, .tableBase, .domainWord);
    core_xfer_model core (.clk_sys, .cpWrite, .cpRead, .cpReg, .cpOp2, .cpWdata, .cpRdata);

    // Clock and hang guard
    always #2.5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            end_sim();
        end
    end

    // Random words from a 16-bit shift register, two steps per word
    function automatic logic [31:0] rnd32();
        seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
        rnd32[31:16] = seed;
        seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
        rnd32[15:0] = seed;
    endfunction

    task automatic report(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Register read against model
    task automatic chkRd(input logic [3:0] r, input logic [2:0] op, input logic [31:0] e);
        logic [31:0] q;
        core.rd(r, op, q);
        report(q, e);
    endtask

    // Output word against model
    task automatic chkOut(input logic [31:0] got, input logic [31:0] e);
        report(got, e);
    endtask

    task automatic wrM(input logic [3:0] r, input logic [31:0] v, input logic [31:0] m);
        core.wr(r, v, m);
        mReg[r] = v & m;
    endtask

    // Control outputs decoded from the model word
    task automatic chkCtl();
        logic [31:0] c;
        c = mReg[1];
        chkOut({mmuEnable, alignCheck}, {c[0], c[1]});
        chkOut({dcacheEnable, icacheEnable}, {c[2], c[12]});
        chkOut({bigEndian, roundRobin}, {c[7], c[14]});
        chkOut({sysProtect, romProtect, clockMode}, {c[8], c[9], c[31:30]});
        chkOut(vectorBase, c[13] ? `VEC_HIGH : `VEC_LOW);
        chkRd(4'h1, 3'h0, c | `CTL_ONES);
    endtask

    task automatic abort(input logic dat, input logic [3:0] t, input logic [3:0] dm,
        input logic [31:0] a);
        @(posedge clk_sys);
        #1;
        dataAbort = dat;
        prefetchAbort = !dat;
        {abortType, abortDomain, abortAddr} = {t, dm, a};
        @(posedge clk_sys);
        #1;
        dataAbort = 1'b0;
        prefetchAbort = 1'b0;
        {abortType, abortDomain, abortAddr} = ~{t, dm, a};
    endtask

    task automatic end_sim();
        $display("checks=%0d errors=%0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial begin
        {reset_n, dataAbort, prefetchAbort, abortType, abortDomain, abortAddr} = '0;
        checkDomain = 4'h0;
        mReg = '{default: 0};
        ident = {`IDENT_MAKER, `IDENT_SPEC_REV, `IDENT_ARCH, `IDENT_PART, `IDENT_LAYOUT};
        cache = {3'h0, `CACHE_CTYPE, `CACHE_SEPARATE, `CACHE_DGEOM, `CACHE_IGEOM};
        repeat (8) @(posedge clk_sys);
        #1;
        reset_n = 1'b1;
        // Reset state of every writable register
        chkCtl();
        for (int r = 2; r < 7; r++)
            if (r != 4) chkRd(r[3:0], 3'h0, mReg[r]);
        // Register zero variants; writes there are dropped
        core.wr(4'h0, 32'hFFFF_FFFF, 32'hFFFF_FFFF);
        chkRd(4'h0, 3'h0, ident);
        chkRd(4'h0, 3'h1, cache);
        chkRd(4'h0, 3'h5, ident);
        // Each control bit alone, clock modes, then random words
        for (int b = 0; b < 15; b++) begin
            wrM(4'h1, 32'h1 << b, `CTL_WR_MASK);
            chkCtl();
        end
        for (int i = 0; i < 12; i++) begin
            d = (i < 4) ? {i[1:0], 30'h0} : rnd32();
            if (d[31:30] == 2'b10)
                d[30] = 1'b1;
            wrM(4'h1, d, `CTL_WR_MASK);
            chkCtl();
        end
        // Table base and domain word
        for (int i = 0; i < 6; i++) begin
            wrM(4'h2, rnd32(), `TABLE_PTR_MASK);
            chkOut(tableBase, mReg[2]);
            chkRd(4'h2, 3'h0, mReg[2]);
            wrM(4'h3, (i == 0) ? 32'hE4E4_E4E4 : rnd32(), 32'hFFFF_FFFF);
            chkOut(domainWord, mReg[3]);
            chkRd(4'h3, 3'h0, mReg[3]);
            for (int n = 0; n < 16; n++) begin
                @(posedge clk_sys);
                #1;
                checkDomain = n[3:0];
                @(posedge clk_sys);
                #1;
                d[1:0] = mReg[3] >> (2 * n);
                chkOut({domainFault, checkPerms, managerMap[n]},
                    {d[1:0] != 2'b01 && d[1:0] != 2'b11, d[1:0] == 2'b01, &d[1:0]});
            end
        end
        // Data aborts captured, prefetch aborts ignored, debugger restore
        for (int i = 0; i < 4; i++) begin
            d = rnd32();
            abort(1'b1, d[3:0], d[7:4], ~d);
            mReg[5] = {24'h0, d[7:4], d[3:0]};
            mReg[6] = ~d;
            chkRd(4'h5, 3'h0, mReg[5]);
            chkRd(4'h6, 3'h0, mReg[6]);
            abort(1'b0, ~d[3:0], ~d[7:4], d);
            chkRd(4'h5, 3'h0, mReg[5]);
            chkRd(4'h6, 3'h0, mReg[6]);
            wrM(4'h5, rnd32(), `FAULT_STAT_MASK);
            wrM(4'h6, rnd32(), 32'hFFFF_FFFF);
            chkRd(4'h5, 3'h0, mReg[5]);
            chkRd(4'h6, 3'h0, mReg[6]);
        end
        // Abort and status write in the same cycle: the abort must win
        d = rnd32();
        fork
            wrM(4'h5, d, `FAULT_STAT_MASK);
            abort(1'b1, ~d[3:0], ~d[7:4], d);
        join
        mReg[5] = {24'h0, ~d[7:4], ~d[3:0]};
        mReg[6] = d;
        chkRd(4'h5, 3'h0, mReg[5]);
        chkRd(4'h6, 3'h0, mReg[6]);
        // Mid-run reset with every register holding written values
        @(posedge clk_sys);
        #1;
        reset_n = 1'b0;
        repeat (2) @(posedge clk_sys);
        #1;
        reset_n = 1'b1;
        mReg = '{default: 0};
        chkCtl();
        for (int r = 2; r < 7; r++)
            if (r != 4) chkRd(r[3:0], 3'h0, mReg[r]);
        end_sim();
    end
endmodule

// ===== verilog/domain_decode.sv
// Per-domain decode of the domain permission word
`include "sysctrl_defs.svh"
module domain_decode (
    // Permission word and domain under check
    input  wire logic [31:0] permWord,
    input  wire logic [3:0]  domainSel,
    // Decoded result
    output logic             domainFault,
    output logic             checkPerms,
    output logic [15:0]      managerMap
);
    import sysctrl_pkg::*;

    logic [1:0] field;

    // Field n sits at bits 2n+1..2n
    genvar gi;
    generate
        for (gi = 0; gi < 16; gi++) begin : g_dom
            assign managerMap[gi] = (permWord[2*gi+1 -: 2] == DOM_MANAGER);
        end
    endgenerate

    // Reserved code is treated as no access, the safe reading
    always_comb begin
        field       = permWord[{domainSel, 1'b1} -: 2];
        domainFault = (field == DOM_NO_ACCESS) || (field == DOM_RESERVED);
        checkPerms  = (field == DOM_CLIENT);
    end
endmodule

// ===== verilog/sysctrl_coproc_mmu_regs.sv
// System control coprocessor register bank for the translation unit
`include "sysctrl_defs.svh"
module sysctrl_coproc_mmu_regs (
    // Clock and reset
    input  wire logic                     clk_sys,
    input  wire logic                     reset_n,
    // Coprocessor transfer port
    input  wire logic                     cpWrite,
    input  wire logic                     cpRead,
    input  wire logic [3:0]               cpReg,
    input  wire logic [2:0]               cpOp2,
    input  wire logic [31:0]              cpWdata,
    output logic [31:0]                   cpRdata,
    // Fault capture from the translation unit
    input  wire logic                     dataAbort,
    input  wire logic                     prefetchAbort,
    input  wire logic [3:0]               abortType,
    input  wire logic [3:0]               abortDomain,
    input  wire logic [31:0]              abortAddr,
    // Domain check request
    input  wire logic [3:0]               checkDomain,
    output logic                          domainFault,
    output logic                          checkPerms,
    output logic [15:0]                   managerMap,
    // Control outputs
    output logic                          mmuEnable,
    output logic                          alignCheck,
    output logic                          dcacheEnable,
    output logic                          icacheEnable,
    output logic                          bigEndian,
    output logic                          sysProtect,
    output logic                          romProtect,
    output logic [31:0]                   vectorBase,
    output logic                          roundRobin,
    output sysctrl_pkg::clock_mode_e      clockMode,
    output logic [31:0]                   tableBase,
    output logic [31:0]                   domainWord
);
    import sysctrl_pkg::*;

    logic [31:0] controlFf;
    logic [31:0] tableBaseFf;
    logic [31:0] domainFf;
    logic [31:0] faultStatusFf;
    logic [31:0] faultAddrFf;
    logic [31:0] nxt_rdata;
    logic [31:0] rdataFf;
    logic [31:0] identWord;
    logic [31:0] cacheWord;

    // Constant words read from register zero
    assign identWord = {`IDENT_MAKER, `IDENT_SPEC_REV, `IDENT_ARCH,
                        `IDENT_PART, `IDENT_LAYOUT};
    assign cacheWord = {3'h0, `CACHE_CTYPE, `CACHE_SEPARATE,
                        `CACHE_DGEOM, `CACHE_IGEOM};

    // Control register; only defined bits are kept
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            controlFf <= `CTL_RESET;
        end else if (cpWrite && cpReg == `REG_CONTROL) begin
            controlFf <= cpWdata & `CTL_WR_MASK;
        end
    end

    // Table base keeps the pointer bits only
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            tableBaseFf <= `RESET_WORD;
        end else if (cpWrite && cpReg == `REG_TABLE_BASE) begin
            tableBaseFf <= cpWdata & `TABLE_PTR_MASK;
        end
    end

    // Domain permission word
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            domainFf <= `RESET_WORD;
        end else if (cpWrite && cpReg == `REG_DOMAIN) begin
            domainFf <= cpWdata;
        end
    end

    // Fault status: a data abort in the same cycle wins over a write
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            faultStatusFf <= `RESET_WORD;
        end else if (dataAbort) begin
            faultStatusFf <= {24'h0, abortDomain, abortType};
        end else if (cpWrite && cpReg == `REG_FAULT_STATUS) begin
            faultStatusFf <= cpWdata & `FAULT_STAT_MASK;
        end
    end

    // Fault address: prefetch aborts never touch it
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            faultAddrFf <= `RESET_WORD;
        end else if (dataAbort) begin
            faultAddrFf <= abortAddr;
        end else if (cpWrite && cpReg == `REG_FAULT_ADDR) begin
            faultAddrFf <= cpWdata;
        end
    end

    // Read mux; register four and unknown numbers read zero
    always_comb begin
        nxt_rdata = `RESET_WORD;
        case (cpReg)
            `REG_IDENT: begin
                if (cpOp2 == `SEL_CACHE_TYPE) begin
                    nxt_rdata = cacheWord;
                end else begin
                    nxt_rdata = identWord;
                end
            end
            `REG_CONTROL:      nxt_rdata = controlFf | `CTL_ONES;
            `REG_TABLE_BASE:   nxt_rdata = tableBaseFf;
            `REG_DOMAIN:       nxt_rdata = domainFf;
            `REG_FAULT_STATUS: nxt_rdata = faultStatusFf;
            `REG_FAULT_ADDR:   nxt_rdata = faultAddrFf;
            default:           nxt_rdata = `RESET_WORD;
        endcase
    end

    // Read data registered one cycle after the read strobe
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rdataFf <= `RESET_WORD;
        end else if (cpRead) begin
            rdataFf <= nxt_rdata;
        end
    end
    assign cpRdata = rdataFf;

    // Control fan-out to the core and caches
    assign mmuEnable    = controlFf[`CTL_MMU];
    assign alignCheck   = controlFf[`CTL_ALIGN];
    assign dcacheEnable = controlFf[`CTL_DCACHE];
    assign icacheEnable = controlFf[`CTL_ICACHE];
    assign bigEndian    = controlFf[`CTL_BIG_END];
    assign sysProtect   = controlFf[`CTL_SYS_PROT];
    assign romProtect   = controlFf[`CTL_ROM_PROT];
    assign roundRobin   = controlFf[`CTL_ROUND_ROBIN];
    assign vectorBase   = controlFf[`CTL_HIGH_VEC] ? `VEC_HIGH : `VEC_LOW;
    // Reserved code passes through as written; software must avoid it
    assign clockMode    = clock_mode_e'(controlFf[`CTL_ASYNC_CLK:`CTL_NOT_FASTBUS]);
    assign tableBase    = tableBaseFf;
    assign domainWord   = domainFf;

    // Domain decode for the translation unit
    domain_decode u_domain (
        .permWord    (domainFf),
        .domainSel   (checkDomain),
        .domainFault (domainFault),
        .checkPerms  (checkPerms),
        .managerMap  (managerMap)
    );

    // Reset, register zero and read-data hold checks
    ctl_reset_a: assert property (@(posedge clk_sys)
        $rose(reset_n) |-> !mmuEnable && !alignCheck && !dcacheEnable && !icacheEnable
                           && !bigEndian && vectorBase == `VEC_LOW)
        else $error("control not cleared after reset");
    cache_read_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        cpRead && cpReg == `REG_IDENT && cpOp2 == `SEL_CACHE_TYPE
        |=> cpRdata[31:29] == 3'h0 && cpRdata[24])
        else $error("cache type word wrong");
    cache_geom_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        cpRead && cpReg == `REG_IDENT && cpOp2 == `SEL_CACHE_TYPE
        |=> cpRdata[28:25] == `CACHE_CTYPE
            && cpRdata[23:0] == {`CACHE_DGEOM, `CACHE_IGEOM})
        else $error("cache geometry fields wrong");
    ident_read_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        cpRead && cpReg == `REG_IDENT && cpOp2 == `SEL_IDENT
        |=> cpRdata[31:24] == `IDENT_MAKER && cpRdata[19:16] == `IDENT_ARCH)
        else $error("identification word wrong");
    ident_default_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        cpRead && cpReg == `REG_IDENT && cpOp2 != `SEL_CACHE_TYPE
        |=> cpRdata[23:20] == `IDENT_SPEC_REV)
        else $error("other opcode values not reading identification");
    rdata_hold_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        !cpRead |=> $stable(cpRdata))
        else $error("read data moved without a read");

    // Control register checks
    mmu_bits_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        cpWrite && cpReg == `REG_CONTROL
        |=> mmuEnable == $past(cpWdata[`CTL_MMU])
            && alignCheck == $past(cpWdata[`CTL_ALIGN]))
        else $error("translation or alignment enable wrong");
    cache_bits_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        cpWrite && cpReg == `REG_CONTROL
        |=> dcacheEnable == $past(cpWdata[`CTL_DCACHE])
            && icacheEnable == $past(cpWdata[`CTL_ICACHE]))
        else $error("cache enable wrong");
    endian_bit_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        cpWrite && cpReg == `REG_CONTROL
        |=> bigEndian == $past(cpWdata[`CTL_BIG_END]))
        else $error("byte order wrong");
    protect_bits_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        cpWrite && cpReg == `REG_CONTROL
        |=> sysProtect == $past(cpWdata[`CTL_SYS_PROT])
            && romProtect == $past(cpWdata[`CTL_ROM_PROT]))
        else $error("protection bits wrong");
    vec_high_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        cpWrite && cpReg == `REG_CONTROL && cpWdata[`CTL_HIGH_VEC]
        |=> vectorBase == `VEC_HIGH
            && roundRobin == $past(cpWdata[`CTL_ROUND_ROBIN]))
        else $error("vector base not high");
    vec_low_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        cpWrite && cpReg == `REG_CONTROL && !cpWdata[`CTL_HIGH_VEC]
        |=> vectorBase == `VEC_LOW)
        else $error("vector base not low");
    clock_mode_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        cpWrite && cpReg == `REG_CONTROL
        |=> clockMode == $past(cpWdata[`CTL_ASYNC_CLK:`CTL_NOT_FASTBUS]))
        else $error("clocking mode wrong");
    ctl_hold_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        !(cpWrite && cpReg == `REG_CONTROL) |=> $stable(controlFf))
        else $error("control changed without a write");

    // Table base and domain checks
    table_load_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        cpWrite && cpReg == `REG_TABLE_BASE
        |=> tableBase == ($past(cpWdata) & `TABLE_PTR_MASK))
        else $error("table base not loaded");
    table_read_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        cpRead && cpReg == `REG_TABLE_BASE |=> cpRdata == $past(tableBase))
        else $error("table base read wrong");
    domain_load_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        cpWrite && cpReg == `REG_DOMAIN |=> domainWord == $past(cpWdata))
        else $error("domain word not loaded");
    manager_bit_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        managerMap[checkDomain] == (domainWord[{checkDomain, 1'b0} +: 2] == 2'h3))
        else $error("manager map wrong");
    dom_fault_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        domainWord[{checkDomain, 1'b0} +: 2] == 2'h0 |-> domainFault && !checkPerms)
        else $error("no-access domain not faulting");
    dom_client_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        domainWord[{checkDomain, 1'b0} +: 2] == 2'h1 |-> !domainFault && checkPerms)
        else $error("client domain not checked");
    dom_manager_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        domainWord[{checkDomain, 1'b0} +: 2] == 2'h3 |-> !domainFault && !checkPerms)
        else $error("manager domain still checked");
    dom_reserved_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        domainWord[{checkDomain, 1'b0} +: 2] == 2'h2 |-> domainFault && !checkPerms)
        else $error("reserved domain not faulting");

    // Fault capture checks
    fault_cap_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        dataAbort |=> faultAddrFf == $past(abortAddr)
                      && faultStatusFf[7:4] == $past(abortDomain))
        else $error("data fault not captured");
    fault_type_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        dataAbort |=> faultStatusFf[3:0] == $past(abortType)
                      && faultStatusFf[31:8] == 24'h0)
        else $error("fault type not captured");
    status_hold_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        !dataAbort && !(cpWrite && cpReg == `REG_FAULT_STATUS) |=> $stable(faultStatusFf))
        else $error("fault status moved without cause");
    prefetch_hold_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        prefetchAbort && !dataAbort && !cpWrite |=> $stable(faultAddrFf))
        else $error("fault address moved on prefetch");
    addr_hold_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        !dataAbort && !(cpWrite && cpReg == `REG_FAULT_ADDR) |=> $stable(faultAddrFf))
        else $error("fault address moved without cause");
    status_write_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        cpWrite && cpReg == `REG_FAULT_STATUS && !dataAbort
        ##1 !dataAbort && !cpWrite
        |=> faultStatusFf[7:0] == $past(cpWdata[7:0], 2))
        else $error("fault status write lost");
    addr_write_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        cpWrite && cpReg == `REG_FAULT_ADDR && !dataAbort
        |=> faultAddrFf == $past(cpWdata))
        else $error("fault address write lost");

    // Main scenarios
    abort_c: cover property (@(posedge clk_sys) disable iff (!reset_n) dataAbort);
    mmu_on_c: cover property (@(posedge clk_sys) disable iff (!reset_n) $rose(mmuEnable));
    cache_rd_c: cover property (@(posedge clk_sys) disable iff (!reset_n)
        cpRead && cpReg == `REG_IDENT && cpOp2 == `SEL_CACHE_TYPE);
    manager_c: cover property (@(posedge clk_sys) disable iff (!reset_n) managerMap != 16'h0);
endmodule

// ===== verilog/sysctrl_defs.svh
// Register numbers, field positions and constants of the system control register bank
`ifndef SYSCTRL_DEFS_SVH
`define SYSCTRL_DEFS_SVH

// Coprocessor register numbers
`define REG_IDENT          4'h0
`define REG_CONTROL        4'h1
`define REG_TABLE_BASE     4'h2
`define REG_DOMAIN         4'h3
`define REG_RESERVED       4'h4
`define REG_FAULT_STATUS   4'h5
`define REG_FAULT_ADDR     4'h6

// Secondary opcode selections on register zero
`define SEL_IDENT          3'h0
`define SEL_CACHE_TYPE     3'h1

// Identification word fields (values arbitrary, neutral)
`define IDENT_MAKER        8'h5A
`define IDENT_SPEC_REV     4'h3
`define IDENT_ARCH         4'h7
`define IDENT_PART         12'h123
`define IDENT_LAYOUT       4'h0

// Cache type word fields
`define CACHE_CTYPE        4'h6
`define CACHE_SEPARATE     1'h1
`define CACHE_DGEOM        12'h1A5
`define CACHE_IGEOM        12'h1A5

// Control register bit positions
`define CTL_MMU            0
`define CTL_ALIGN          1
`define CTL_DCACHE         2
`define CTL_BIG_END        7
`define CTL_SYS_PROT       8
`define CTL_ROM_PROT       9
`define CTL_ICACHE         12
`define CTL_HIGH_VEC       13
`define CTL_ROUND_ROBIN    14
`define CTL_NOT_FASTBUS    30
`define CTL_ASYNC_CLK      31

// Writable control bits and fixed-one bits read back
`define CTL_WR_MASK        32'hC000_7387
`define CTL_ONES           32'h0000_0078
`define CTL_RESET          32'h0000_0000

// Table base pointer mask, vectors, fault status width
`define TABLE_PTR_MASK     32'hFFFF_C000
`define VEC_LOW            32'h0000_0000
`define VEC_HIGH           32'hFFFF_0000
`define FAULT_STAT_MASK    32'h0000_00FF
`define RESET_WORD         32'h0000_0000

`endif

// ===== verilog/sysctrl_pkg.sv
// Types shared by the system control register bank
package sysctrl_pkg;
    typedef enum logic [1:0] {
        CLK_FASTBUS,
        CLK_SYNC,
        CLK_RESERVED,
        CLK_ASYNC
    } clock_mode_e;

    typedef enum logic [1:0] {
        DOM_NO_ACCESS,
        DOM_CLIENT,
        DOM_RESERVED,
        DOM_MANAGER
    } domain_access_e;
endpackage
